// ### verilog/core_supervisor_pkg.sv
// Constants for the processor core supervisor: register map, reset values, field positions.
// Assumes a word-addressed control port with 16-bit registers.
package core_supervisor_pkg;
    localparam int REG_AW = 16;
    localparam int REG_DW = 16;
    localparam logic [15:0] ADDR_CHK_EXP_HIGH = 16'hE200;
    localparam logic [15:0] ADDR_CHK_EXP_LOW = 16'hE201;
    localparam logic [15:0] ADDR_CHK_ENABLE = 16'hE202;
    localparam logic [15:0] ADDR_WD_ENABLE = 16'hE210;
    localparam logic [15:0] ADDR_WD_LIMIT_HIGH = 16'hE211;
    localparam logic [15:0] ADDR_WD_LIMIT_LOW = 16'hE212;
    localparam logic [15:0] ADDR_CIRC_BOUNDARY = 16'hE21F;
    localparam logic [15:0] ADDR_CHK_ERR_FLAG = 16'hE225;
    localparam logic [15:0] ADDR_WD_ERR_FLAG = 16'hE226;
    localparam logic [15:0] ADDR_ERR_AUTO_MUTE = 16'hE227;
    localparam logic [15:0] ADDR_CORE_RUN = 16'hE228;
    localparam logic [15:0] ADDR_PEAK_CYCLES = 16'hE229;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [13:0] RST_CIRC_BOUNDARY = 14'h1F00;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_CORE_RUN = 0;
    localparam int BIT_ERR_FLAG = 0;
    localparam int BIT_MUTE_ON_WD = 0;
    localparam int BIT_MUTE_ON_CHK = 1;
    localparam int CIRC_W = 14;
    localparam int PEAK_W = 16;
    localparam int CHK_W = 32;
    localparam int PMEM_DW = 43;
    localparam int PMEM_AW = 12;
    localparam int PMEM_WORDS = 4096;
    localparam int CHECK_FRAMES = 4096;
    localparam int PARAM_DW = 28;
    localparam int PARAM_AW = 12;
    localparam int SAFELOAD_WORDS = 8;
    localparam logic [31:0] CHK_POLY = 32'h04C11DB7;
    localparam logic [31:0] CHK_SEED = 32'hFFFFFFFF;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_READ = 2'b01,
        SCAN_DRAIN = 2'b10,
        SCAN_CMP = 2'b11
    } scan_state_t;
endpackage : core_supervisor_pkg

// ### verilog/core_supervisor.sv
// Processor core supervisor: run control, program checksum, watchdog, peak counter.
// Assumes a one-cycle register port, a program memory read port that returns data in the same cycle as the address,
// and a core that reports its frame start request and jump-to-start events.
`timescale 1ns/1ps
`default_nettype none
module core_supervisor #(
    parameter int CHECK_FRAMES = core_supervisor_pkg::CHECK_FRAMES,
    parameter int PMEM_WORDS = core_supervisor_pkg::PMEM_WORDS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    input wire logic frame_start,
    input wire logic pc_jump_to_start,
    output logic core_run_ff,
    output logic core_start_ff,
    output logic pc_hold_ff,
    output logic serial_out_zero_ff,
    output logic [11:0] pmem_rd_addr_ff,
    output logic pmem_rd_en_ff,
    input wire logic [42:0] pmem_rd_data,
    input wire logic mp_select_chk,
    input wire logic mp_select_wd,
    output logic mp_chk_flag_ff,
    output logic mp_wd_flag_ff,
    output logic [13:0] circular_boundary_ff,
    input wire logic param_wr,
    input wire logic [11:0] param_addr,
    input wire logic [27:0] param_wdata,
    output logic param_wr_ff,
    output logic [11:0] param_addr_ff,
    output logic [27:0] param_wdata_ff,
    output logic param_safeload_ff
);
    initial
    begin
        if (CHECK_FRAMES < 1 || CHECK_FRAMES > 65536)
            $error("CHECK_FRAMES out of range");
        if (PMEM_WORDS < 2 || PMEM_WORDS > core_supervisor_pkg::PMEM_WORDS)
            $error("PMEM_WORDS out of range");
    end

    // Folds one program word into the running checksum, most significant bit first
    function automatic logic [31:0] chk_update(input logic [31:0] crc, input logic [42:0] word);
        logic [31:0] c;
        c = crc;
        for (int i = core_supervisor_pkg::PMEM_DW - 1; i >= 0; i--)
        begin
            if (c[31] ^ word[i])
                c = {c[30:0], 1'b0} ^ core_supervisor_pkg::CHK_POLY;
            else
                c = {c[30:0], 1'b0};
        end
        return c;
    endfunction : chk_update

    logic [15:0] chk_exp_high_ff;
    logic [15:0] chk_exp_low_ff;
    logic chk_enable_ff;
    logic wd_enable_ff;
    logic [15:0] wd_limit_high_ff;
    logic [15:0] wd_limit_low_ff;
    logic [1:0] auto_mute_ff;
    logic run_bit_ff;
    logic chk_err_ff;
    logic wd_err_ff;
    logic [15:0] peak_ff;
    logic [15:0] pass_len_ff;
    logic [31:0] cycle_cnt_ff;
    logic [15:0] frame_cnt_ff;
    core_supervisor_pkg::scan_state_t scan_ff;
    core_supervisor_pkg::scan_state_t nxt_scan;
    logic [12:0] scan_addr_ff;
    logic [31:0] crc_ff;
    logic check_due;
    logic scan_last;
    logic chk_mismatch;
    logic wd_hit;
    logic start_now;

    assign start_now = frame_start & run_bit_ff;
    assign check_due = start_now & chk_enable_ff
        & (frame_cnt_ff == 16'(CHECK_FRAMES - 1));
    assign scan_last = (scan_addr_ff == 13'(PMEM_WORDS));
    assign chk_mismatch = (crc_ff != {chk_exp_high_ff, chk_exp_low_ff});
    assign wd_hit = wd_enable_ff & ~pc_hold_ff
        & (cycle_cnt_ff >= {wd_limit_high_ff, wd_limit_low_ff});

    // Writable registers
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            chk_exp_high_ff <= core_supervisor_pkg::RST_ZERO;
            chk_exp_low_ff <= core_supervisor_pkg::RST_ZERO;
            chk_enable_ff <= 1'b0;
            wd_enable_ff <= 1'b0;
            wd_limit_high_ff <= core_supervisor_pkg::RST_ZERO;
            wd_limit_low_ff <= core_supervisor_pkg::RST_ZERO;
            auto_mute_ff <= 2'h0;
            run_bit_ff <= 1'b0;
            circular_boundary_ff <= core_supervisor_pkg::RST_CIRC_BOUNDARY;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                core_supervisor_pkg::ADDR_CHK_EXP_HIGH: chk_exp_high_ff <= reg_wdata;
                core_supervisor_pkg::ADDR_CHK_EXP_LOW: chk_exp_low_ff <= reg_wdata;
                core_supervisor_pkg::ADDR_CHK_ENABLE:
                    chk_enable_ff <= reg_wdata[core_supervisor_pkg::BIT_ENABLE];
                core_supervisor_pkg::ADDR_WD_ENABLE:
                    wd_enable_ff <= reg_wdata[core_supervisor_pkg::BIT_ENABLE];
                core_supervisor_pkg::ADDR_WD_LIMIT_HIGH: wd_limit_high_ff <= reg_wdata;
                core_supervisor_pkg::ADDR_WD_LIMIT_LOW: wd_limit_low_ff <= reg_wdata;
                core_supervisor_pkg::ADDR_ERR_AUTO_MUTE: auto_mute_ff <= reg_wdata[1:0];
                core_supervisor_pkg::ADDR_CORE_RUN:
                    run_bit_ff <= reg_wdata[core_supervisor_pkg::BIT_CORE_RUN];
                core_supervisor_pkg::ADDR_CIRC_BOUNDARY:
                    circular_boundary_ff <= reg_wdata[core_supervisor_pkg::CIRC_W - 1:0];
                default:
                begin
                end
            endcase
        end
    end

    // Register read port, answer one cycle after the strobe
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            reg_rdata_ff <= core_supervisor_pkg::RST_ZERO;
            reg_rvalid_ff <= 1'b0;
        end
        else
        begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd)
            begin
                case (reg_addr)
                    core_supervisor_pkg::ADDR_CHK_EXP_HIGH: reg_rdata_ff <= chk_exp_high_ff;
                    core_supervisor_pkg::ADDR_CHK_EXP_LOW: reg_rdata_ff <= chk_exp_low_ff;
                    core_supervisor_pkg::ADDR_CHK_ENABLE: reg_rdata_ff <= {15'h0000, chk_enable_ff};
                    core_supervisor_pkg::ADDR_WD_ENABLE: reg_rdata_ff <= {15'h0000, wd_enable_ff};
                    core_supervisor_pkg::ADDR_WD_LIMIT_HIGH: reg_rdata_ff <= wd_limit_high_ff;
                    core_supervisor_pkg::ADDR_WD_LIMIT_LOW: reg_rdata_ff <= wd_limit_low_ff;
                    core_supervisor_pkg::ADDR_CIRC_BOUNDARY:
                        reg_rdata_ff <= {2'h0, circular_boundary_ff};
                    core_supervisor_pkg::ADDR_CHK_ERR_FLAG:
                        reg_rdata_ff <= {15'h0000, chk_err_ff};
                    core_supervisor_pkg::ADDR_WD_ERR_FLAG:
                        reg_rdata_ff <= {15'h0000, wd_err_ff};
                    core_supervisor_pkg::ADDR_ERR_AUTO_MUTE: reg_rdata_ff <= {14'h0000, auto_mute_ff};
                    core_supervisor_pkg::ADDR_CORE_RUN: reg_rdata_ff <= {15'h0000, run_bit_ff};
                    core_supervisor_pkg::ADDR_PEAK_CYCLES: reg_rdata_ff <= peak_ff;
                    default: reg_rdata_ff <= core_supervisor_pkg::RST_ZERO;
                endcase
            end
        end
    end

    // Core run, start pulse and output muting
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            core_run_ff <= 1'b0;
            core_start_ff <= 1'b0;
            serial_out_zero_ff <= 1'b1;
        end
        else
        begin
            core_run_ff <= run_bit_ff;
            core_start_ff <= start_now;
            serial_out_zero_ff <= ~run_bit_ff
                | (auto_mute_ff[core_supervisor_pkg::BIT_MUTE_ON_CHK] & chk_err_ff)
                | (auto_mute_ff[core_supervisor_pkg::BIT_MUTE_ON_WD] & wd_err_ff);
        end
    end

    // Program counter park at start address until the next start pulse
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            pc_hold_ff <= 1'b1;
        else if (start_now)
            pc_hold_ff <= 1'b0;
        else if (pc_jump_to_start || !run_bit_ff)
            pc_hold_ff <= 1'b1;
    end

    // Per-frame cycle counter and pass length
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cycle_cnt_ff <= 32'h00000000;
            pass_len_ff <= 16'h0000;
        end
        else if (start_now)
            cycle_cnt_ff <= 32'h00000000;
        else if (!pc_hold_ff)
        begin
            if (cycle_cnt_ff != 32'hFFFFFFFF)
                cycle_cnt_ff <= cycle_cnt_ff + 32'h00000001;
            if (pc_jump_to_start)
                pass_len_ff <= (cycle_cnt_ff[31:16] != 16'h0000) ? 16'hFFFF
                    : cycle_cnt_ff[15:0] + 16'h0001;
        end
    end

    // Peak register refreshed on every start pulse
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            peak_ff <= 16'h0000;
        else if (start_now)
            peak_ff <= pass_len_ff;
    end

    // Watchdog error flag
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            wd_err_ff <= 1'b0;
        else if (!wd_enable_ff)
            wd_err_ff <= 1'b0;
        else if (wd_hit)
            wd_err_ff <= 1'b1;
    end

    // Frame counter for the periodic checksum
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            frame_cnt_ff <= 16'h0000;
        else if (!chk_enable_ff)
            frame_cnt_ff <= 16'h0000;
        else if (start_now)
            frame_cnt_ff <= check_due ? 16'h0000 : frame_cnt_ff + 16'h0001;
    end

    // Checksum scan sequencer
    always_comb
    begin
        nxt_scan = scan_ff;
        case (scan_ff)
            core_supervisor_pkg::SCAN_IDLE:
                if (check_due)
                    nxt_scan = core_supervisor_pkg::SCAN_READ;
            core_supervisor_pkg::SCAN_READ:
                if (scan_last)
                    nxt_scan = core_supervisor_pkg::SCAN_DRAIN;
            core_supervisor_pkg::SCAN_DRAIN:
                nxt_scan = core_supervisor_pkg::SCAN_CMP;
            core_supervisor_pkg::SCAN_CMP:
                nxt_scan = core_supervisor_pkg::SCAN_IDLE;
            default:
                nxt_scan = core_supervisor_pkg::SCAN_IDLE;
        endcase
        if (!chk_enable_ff)
            nxt_scan = core_supervisor_pkg::SCAN_IDLE;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            scan_ff <= core_supervisor_pkg::SCAN_IDLE;
        else
            scan_ff <= nxt_scan;
    end

    // Program memory walk and checksum accumulation
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            scan_addr_ff <= 13'h0000;
            pmem_rd_addr_ff <= 12'h000;
            pmem_rd_en_ff <= 1'b0;
            crc_ff <= core_supervisor_pkg::CHK_SEED;
        end
        else
        begin
            pmem_rd_en_ff <= (nxt_scan == core_supervisor_pkg::SCAN_READ);
            if (scan_ff != core_supervisor_pkg::SCAN_READ || !chk_enable_ff)
                scan_addr_ff <= 13'h0000;
            if (scan_ff == core_supervisor_pkg::SCAN_IDLE)
                crc_ff <= core_supervisor_pkg::CHK_SEED;
            else if (pmem_rd_en_ff)
                crc_ff <= chk_update(crc_ff, pmem_rd_data);
            if (nxt_scan == core_supervisor_pkg::SCAN_READ)
            begin
                pmem_rd_addr_ff <= scan_addr_ff[11:0];
                scan_addr_ff <= scan_addr_ff + 13'h0001;
            end
        end
    end

    // Checksum error flag
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            chk_err_ff <= 1'b0;
        else if (!chk_enable_ff)
            chk_err_ff <= 1'b0;
        else if (scan_ff == core_supervisor_pkg::SCAN_CMP && chk_mismatch)
            chk_err_ff <= 1'b1;
    end

    // Multipurpose pin flag outputs
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            mp_chk_flag_ff <= 1'b0;
            mp_wd_flag_ff <= 1'b0;
        end
        else
        begin
            mp_chk_flag_ff <= mp_select_chk & chk_err_ff;
            mp_wd_flag_ff <= mp_select_wd & wd_err_ff;
        end
    end

    // Parameter memory write path with safe-load slot marker
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            param_wr_ff <= 1'b0;
            param_addr_ff <= 12'h000;
            param_wdata_ff <= 28'h0000000;
            param_safeload_ff <= 1'b0;
        end
        else
        begin
            param_wr_ff <= param_wr;
            param_addr_ff <= param_addr;
            param_wdata_ff <= param_wdata;
            param_safeload_ff <= param_wr
                & (param_addr < 12'(core_supervisor_pkg::SAFELOAD_WORDS));
        end
    end
endmodule : core_supervisor
`default_nettype wire

// ### tb/core_supervisor_assertions.sv
// Port-level checker for the core supervisor, bound to each instance.
// Assumes one clock domain with an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module core_supervisor_assertions #(
    parameter int PMEM_WORDS = 8
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic frame_start,
    input wire logic pc_jump_to_start,
    input wire logic core_run_ff,
    input wire logic core_start_ff,
    input wire logic pc_hold_ff,
    input wire logic serial_out_zero_ff,
    input wire logic [11:0] pmem_rd_addr_ff,
    input wire logic pmem_rd_en_ff,
    input wire logic mp_select_chk,
    input wire logic mp_select_wd,
    input wire logic mp_chk_flag_ff,
    input wire logic mp_wd_flag_ff,
    input wire logic [13:0] circular_boundary_ff,
    input wire logic param_wr,
    input wire logic [11:0] param_addr,
    input wire logic param_wr_ff,
    input wire logic [11:0] param_addr_ff,
    input wire logic param_safeload_ff
);
    logic [2:0] clr_cnt_ff;
    logic en_wr;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    assign en_wr = reg_wr && (reg_addr == 16'hE202 || reg_addr == 16'hE210);
    // Window after a cause that may lower a flag pin
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            clr_cnt_ff <= 3'h0;
        else if (en_wr || !mp_select_chk || !mp_select_wd)
            clr_cnt_ff <= 3'h5;
        else if (clr_cnt_ff != 3'h0)
            clr_cnt_ff <= clr_cnt_ff - 3'h1;
    end
    run_copy_a: assert property (reg_wr && reg_addr == 16'hE228 |-> ##2
        core_run_ff == $past(reg_wdata[0], 2)) else $error("run output differs from write");
    run_read_a: assert property (reg_rd && reg_addr == 16'hE228 |=>
        reg_rdata_ff == {15'h0000, core_run_ff}) else $error("run readback wrong");
    no_start_a: assert property (!$past(frame_start) || !core_run_ff |-> !core_start_ff)
        else $error("start pulse without cause");
    start_a: assert property ($past(frame_start) && core_run_ff
        |-> core_start_ff && !pc_hold_ff) else $error("start request not passed on");
    park_a: assert property (pc_jump_to_start && !frame_start |=> pc_hold_ff)
        else $error("counter not parked after jump");
    wait_start_a: assert property (pc_hold_ff && !frame_start |=> pc_hold_ff)
        else $error("counter left start without start pulse");
    halt_zero_a: assert property (!core_run_ff |-> serial_out_zero_ff)
        else $error("serial outputs live while halted");
    circ_read_a: assert property (reg_rd && reg_addr == 16'hE21F |=>
        reg_rdata_ff == {2'h0, $past(circular_boundary_ff)}) else $error("boundary readback");
    flag_sticky_a: assert property ($fell(mp_chk_flag_ff) || $fell(mp_wd_flag_ff)
        |-> clr_cnt_ff != 3'h0) else $error("error flag dropped without clear");
    scan_step_a: assert property (pmem_rd_en_ff && pmem_rd_addr_ff != 12'(PMEM_WORDS - 1)
        |=> pmem_rd_en_ff && pmem_rd_addr_ff == $past(pmem_rd_addr_ff) + 12'h001)
        else $error("program scan not sequential");
    safeload_a: assert property (param_wr |=> param_wr_ff && param_addr_ff == $past(param_addr)
        && param_safeload_ff == ($past(param_addr) < 12'h008)) else $error("parameter path");
    start_c: cover property (core_start_ff);
    chk_flag_c: cover property ($rose(mp_chk_flag_ff));
    wd_flag_c: cover property ($rose(mp_wd_flag_ff));
endmodule : core_supervisor_assertions
bind core_supervisor core_supervisor_assertions #(.PMEM_WORDS(PMEM_WORDS)) i_checker (
    .clk_sys, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff, .frame_start,
    .pc_jump_to_start, .core_run_ff, .core_start_ff, .pc_hold_ff, .serial_out_zero_ff,
    .pmem_rd_addr_ff, .pmem_rd_en_ff, .mp_select_chk, .mp_select_wd, .mp_chk_flag_ff,
    .mp_wd_flag_ff, .circular_boundary_ff, .param_wr, .param_addr, .param_wr_ff,
    .param_addr_ff, .param_safeload_ff);
`default_nettype wire

// ### tb/host_model.sv
// Host controller model driving the supervisor register port.
// Assumes the supervisor clock; one request at a time.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input wire logic clk_sys,
    output logic [15:0] reg_addr,
    output logic reg_wr,
    output logic [15:0] reg_wdata,
    output logic reg_rd,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff
);
    initial
    begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    // Read data is taken with the valid pulse one cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(posedge clk_sys);
        d = (reg_rvalid_ff === 1'b1) ? reg_rdata_ff : 16'hXXXX;
    endtask : rd
    task automatic wr32(input logic [15:0] a_high, input logic [31:0] v);
        wr(a_high, v[31:16]);
        wr(a_high + 16'h0001, v[15:0]);
    endtask : wr32
endmodule : host_model
`default_nettype wire

// ### tb/tb.sv
// Self-checking bench: host model on the register port, memory and core events here.
// Assumes the shortened counts CHECK_FRAMES=4 and PMEM_WORDS=8.
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int NW = 8;
    logic clk_sys = 1'b0, resetn = 1'b0, frame_start = 1'b0, pc_jump_to_start = 1'b0;
    logic mp_select_chk = 1'b1, mp_select_wd = 1'b1, param_wr = 1'b0;
    logic [11:0] param_addr = 12'h000;
    logic [27:0] param_wdata = 28'h0000000;
    logic [42:0] pmem_rd_data;
    logic [15:0] reg_addr, reg_wdata, reg_rdata_ff, p1, p2;
    logic reg_wr, reg_rd, reg_rvalid_ff, core_run_ff, core_start_ff, pc_hold_ff;
    logic serial_out_zero_ff, pmem_rd_en_ff, mp_chk_flag_ff, mp_wd_flag_ff;
    logic param_wr_ff, param_safeload_ff;
    logic [11:0] pmem_rd_addr_ff, param_addr_ff;
    logic [27:0] param_wdata_ff;
    logic [13:0] circular_boundary_ff;
    logic [31:0] crc;
    int errors = 0, n_compared = 0, cycles = 0;
    always #5 clk_sys = ~clk_sys;
    core_supervisor #(.CHECK_FRAMES(4), .PMEM_WORDS(NW)) i_dut (.clk_sys, .resetn, .reg_addr,
        .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff, .reg_rvalid_ff, .frame_start,
        .pc_jump_to_start, .core_run_ff, .core_start_ff, .pc_hold_ff, .serial_out_zero_ff,
        .pmem_rd_addr_ff, .pmem_rd_en_ff, .pmem_rd_data, .mp_select_chk, .mp_select_wd,
        .mp_chk_flag_ff, .mp_wd_flag_ff, .circular_boundary_ff, .param_wr, .param_addr,
        .param_wdata, .param_wr_ff, .param_addr_ff, .param_wdata_ff, .param_safeload_ff);
    host_model host (.clk_sys, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_ff,
        .reg_rvalid_ff);
    function automatic logic [42:0] pat(input logic [11:0] a);
        return 43'h2ABCDEF0123 ^ {31'h00000000, a};
    endfunction : pat
    // Program memory shows the addressed word while the read enable stands, else junk
    assign pmem_rd_data = pmem_rd_en_ff ? pat(pmem_rd_addr_ff) : ~pat(pmem_rd_addr_ff);
    function automatic logic [31:0] crc_of();
        logic [31:0] c;
        logic [42:0] w;
        c = core_supervisor_pkg::CHK_SEED;
        for (int a = 0; a < NW; a++)
        begin
            w = pat(12'(a));
            for (int i = 42; i >= 0; i--)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ w[i]) ? core_supervisor_pkg::CHK_POLY : 32'h0);
        end
        return c;
    endfunction : crc_of
    task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        logic [15:0] v;
        host.rd(a, v);
        chk($sformatf("register %h", a), 32'(v), 32'(e));
    endtask : rdc
    task automatic settle();
        @(posedge clk_sys);
        #1;
    endtask : settle
    task automatic rst();
        @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        resetn <= 1'b1;
        #1;
        chk("reset outputs", 32'({pc_hold_ff, serial_out_zero_ff, core_run_ff}), 32'h6);
    endtask : rst
    task automatic pass(input int k, input logic go);
        @(posedge clk_sys);
        frame_start <= 1'b1;
        @(posedge clk_sys);
        frame_start <= 1'b0;
        #1;
        chk("start and hold", 32'({core_start_ff, pc_hold_ff}), 32'({go, ~go}));
        repeat (k) @(posedge clk_sys);
        pc_jump_to_start <= 1'b1;
        @(posedge clk_sys);
        pc_jump_to_start <= 1'b0;
    endtask : pass
    task automatic t_regs();
        logic [15:0] ad [12] = '{16'hE200, 16'hE201, 16'hE202, 16'hE210, 16'hE211, 16'hE212,
            16'hE21F, 16'hE225, 16'hE226, 16'hE227, 16'hE228, 16'hE230};
        logic [15:0] ms [12] = '{16'hFFFF, 16'hFFFF, 16'h0001, 16'h0001, 16'hFFFF, 16'hFFFF,
            16'h3FFF, 16'h0000, 16'h0000, 16'h0003, 16'h0001, 16'h0000};
        logic [15:0] rs;
        for (int i = 0; i < 12; i++)
        begin
            rs = (ad[i] == 16'hE21F) ? 16'h1F00 : 16'h0000;
            rdc(ad[i], rs);
            host.wr(ad[i], 16'hFFFF);
            rdc(ad[i], ms[i]);
            host.wr(ad[i], rs);
        end
        chk("boundary port", 32'(circular_boundary_ff), 32'h1F00);
    endtask : t_regs
    task automatic t_param();
        @(posedge clk_sys);
        param_wr <= 1'b1;
        param_addr <= 12'h007;
        param_wdata <= 28'hABCDEF1;
        @(posedge clk_sys);
        param_addr <= 12'h008;
        #1;
        chk("safe-load 7", 32'({param_safeload_ff, param_wdata_ff}), 32'h1ABCDEF1);
        @(posedge clk_sys);
        param_wr <= 1'b0;
        #1;
        chk("safe-load 8", 32'({param_safeload_ff, param_addr_ff}), 32'h008);
    endtask : t_param
    task automatic t_run();
        pass(3, 1'b0);
        host.wr(16'hE228, 16'h0001);
        settle();
        chk("zero while running", 32'(serial_out_zero_ff), 32'h0);
        pass(4, 1'b1);
        pass(7, 1'b1);
        host.rd(16'hE229, p1);
        pass(2, 1'b1);
        host.rd(16'hE229, p2);
        chk("peak step", 32'(p2 - p1), 32'h3);
        host.wr(16'hE228, 16'h0000);
        settle();
        chk("zero after halt", 32'(serial_out_zero_ff), 32'h1);
        pass(2, 1'b0);
    endtask : t_run
    task automatic t_wd();
        host.wr32(16'hE211, 32'h00010014);
        host.wr(16'hE210, 16'h0001);
        host.wr(16'hE227, 16'h0002);
        host.wr(16'hE228, 16'h0001);
        pass(30, 1'b1);
        host.wr(16'hE211, 16'h0000);
        pass(15, 1'b1);
        pass(15, 1'b1);
        rdc(16'hE226, 16'h0000);
        pass(30, 1'b1);
        rdc(16'hE226, 16'h0001);
        chk("wd pin", 32'({mp_wd_flag_ff, serial_out_zero_ff}), 32'h2);
        host.wr(16'hE227, 16'h0001);
        settle();
        chk("wd mute", 32'(serial_out_zero_ff), 32'h1);
        @(posedge clk_sys);
        mp_select_wd <= 1'b0;
        repeat (3) settle();
        chk("wd pin deselected", 32'(mp_wd_flag_ff), 32'h0);
        @(posedge clk_sys);
        mp_select_wd <= 1'b1;
        rdc(16'hE226, 16'h0001);
        host.wr(16'hE210, 16'h0000);
        rdc(16'hE226, 16'h0000);
        rst();
    endtask : t_wd
    task automatic t_chk();
        host.wr32(16'hE200, crc);
        host.wr(16'hE202, 16'h0001);
        host.wr(16'hE228, 16'h0001);
        repeat (8) pass(20, 1'b1);
        rdc(16'hE225, 16'h0000);
        host.wr(16'hE201, crc[15:0] ^ 16'h0001);
        repeat (8) pass(20, 1'b1);
        rdc(16'hE225, 16'h0001);
        chk("crc pin", 32'({mp_chk_flag_ff, serial_out_zero_ff}), 32'h2);
        host.wr(16'hE227, 16'h0002);
        settle();
        chk("crc mute", 32'(serial_out_zero_ff), 32'h1);
        host.wr32(16'hE200, crc);
        repeat (8) pass(20, 1'b1);
        rdc(16'hE225, 16'h0001);
        host.wr(16'hE202, 16'h0000);
        rdc(16'hE225, 16'h0000);
        host.wr(16'hE202, 16'h0001);
        repeat (8) pass(20, 1'b1);
        rdc(16'hE225, 16'h0000);
    endtask : t_chk
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            results();
        end
    end
    initial
    begin
        crc = crc_of();
        rst();
        t_regs();
        t_param();
        t_run();
        t_wd();
        t_chk();
        results();
    end
endmodule : tb
`default_nettype wire
